// ===== hw/dim_monitor.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "dim_defines.svh"
module dim_monitor (
  input  wire logic         i_sys_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_line_n,
  input  wire logic [7:0]   i_addr,
  input  wire logic [31:0]  i_wr_data,
  input  wire logic         i_wr_en,
  input  wire logic         i_rd_en,
  output logic [31:0]       o_rd_data,
  output logic              o_irq,
  output logic              o_level,
  output logic              o_latched,
  output logic              o_alarm,
  output logic              o_log_valid,
  output dim_pkg::dim_log_t o_log,
  output logic              o_trap_valid,
  output dim_pkg::dim_trap_t o_trap
);
  import dim_pkg::*;

  dim_cfg_t               cfg;            // control register
  logic                   sync_q;         // synchronised pin level
  logic                   line_act;       // contact closed
  logic                   rep_level;      // reported level after inversion
  logic                   prev_level;     // reported level one cycle ago
  logic                   rise;           // inactive to active
  logic                   fall;           // active to inactive
  logic                   lat_hit;        // selected transition seen
  dim_state_t             state;          // alarm state
  dim_state_t             next_state;
  logic                   raise;          // alarm goes up this cycle
  logic                   clear;          // alarm goes down this cycle
  logic [`DIM_EV_W-1:0]   irq_stat;       // sticky events
  logic [`DIM_EV_W-1:0]   irq_mask;       // event enables
  logic [`DIM_EV_W-1:0]   next_irq_stat;
  logic [`DIM_EV_W-1:0]   events;
  logic                   wr_ctrl;
  logic                   wr_cmd;
  logic                   wr_mask;
  logic                   rd_stat;
  logic                   alm_clr_cmd;    // host clear of a held alarm
  logic                   lat_clr_cmd;    // host clear of the latch
  logic [31:0]            rd_mux;

  // pin into the clock domain before anything looks at it
  dim_sync #(
    .STAGES  (`DIM_SYNC_STAGES),
    .RST_VAL (`DIM_PIN_IDLE)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_d       (i_line_n),
    .o_q       (sync_q)
  ); // RQ12

  // register decode
  assign wr_ctrl     = i_wr_en && (i_addr == `DIM_OFS_CTRL);
  assign wr_cmd      = i_wr_en && (i_addr == `DIM_OFS_CMD);
  assign wr_mask     = i_wr_en && (i_addr == `DIM_OFS_IRQ_MASK);
  assign rd_stat     = i_rd_en && (i_addr == `DIM_OFS_IRQ_STAT);
  assign alm_clr_cmd = wr_cmd && i_wr_data[`DIM_CMD_ALM_CLR];
  assign lat_clr_cmd = wr_cmd && i_wr_data[`DIM_CMD_LAT_CLR];

  // the pin is pulled high, so a closed contact reads low
  assign line_act  = ~sync_q;                  // RQ11
  assign rep_level = line_act ^ cfg.invert;    // RQ1

  // edges only count in input mode; output mode freezes edge detection, the level still follows
  assign rise = ~cfg.out_mode & rep_level & ~prev_level;   // RQ10 RQ12
  assign fall = ~cfg.out_mode & ~rep_level & prev_level;   // RQ10 RQ12

  // latch decode; toggling invert also looks like an edge, by design
  assign lat_hit = ((cfg.latch == DIM_LATCH_RISE) && rise) ||
                   ((cfg.latch == DIM_LATCH_FALL) && fall);  // RQ2

  // control register, reset leaves every option at its default
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cfg <= dim_cfg_t'(`DIM_CTRL_RST);      // RQ1 RQ2 RQ5 RQ10
    else if (wr_ctrl)
      cfg <= dim_cfg_t'(i_wr_data[`DIM_CTRL_W-1:0]);
  end

  // mask register
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      irq_mask <= '0;
    else if (wr_mask)
      irq_mask <= i_wr_data[`DIM_EV_W-1:0];
  end

  // edge reference and reported level
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prev_level <= 1'b0;
      o_level    <= 1'b0;
    end
    else
    begin
      prev_level <= rep_level;  // RQ12
      o_level    <= rep_level;  // RQ1
    end
  end

  // latch flag; a capture in the clear cycle wins
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_latched <= 1'b0;
    else
      o_latched <= lat_hit | (o_latched & ~lat_clr_cmd);  // RQ2
  end

  // alarm decision
  always_comb
  begin
    raise = 1'b0;
    clear = 1'b0;
    unique case (state)
      DIM_ST_QUIET:
      begin
        // a raise needs the transition, a level alone is not enough
        raise = ((cfg.trig == DIM_TRIG_INACT) && fall) ||   // RQ3
                ((cfg.trig == DIM_TRIG_ACT) && rise);       // RQ4
      end
      DIM_ST_ALARM:
      begin
        if ((cfg.trig != DIM_TRIG_INACT) && (cfg.trig != DIM_TRIG_ACT))
          clear = 1'b1;                                     // RQ5
        else if (alm_clr_cmd)
          clear = 1'b1;                                     // RQ7
        else if (!cfg.manual && !cfg.out_mode)
          // cause gone: input back at the level opposite the trigger
          clear = (cfg.trig == DIM_TRIG_INACT) ? rep_level : ~rep_level;  // RQ6
      end
    endcase
    next_state = raise ? DIM_ST_ALARM : (clear ? DIM_ST_QUIET : state);
  end

  // alarm state
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state   <= DIM_ST_QUIET;
      o_alarm <= 1'b0;
    end
    else
    begin
      state   <= next_state;                     // RQ3 RQ4 RQ6 RQ7
      o_alarm <= (next_state == DIM_ST_ALARM);
    end
  end

  // log notification, payload holds until the next event
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_log_valid <= 1'b0;
      o_log       <= '0;
    end
    else
    begin
      o_log_valid <= cfg.log_en & (raise | clear);   // RQ8
      if (cfg.log_en && (raise || clear))
        o_log <= '{severity: `DIM_SEV_CRIT, value: rep_level};  // RQ8
    end
  end

  // trap notification
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_trap_valid <= 1'b0;
      o_trap       <= '0;
    end
    else
    begin
      o_trap_valid <= cfg.trap_en & (raise | clear);  // RQ9
      if (cfg.trap_en && (raise || clear))
        o_trap <= '{severity: `DIM_SEV_CRIT, raised: raise};  // RQ9
    end
  end

  // sticky events: a new event beats the clearing read
  assign events        = {lat_hit, clear, raise};
  assign next_irq_stat = events | (irq_stat & ~{`DIM_EV_W{rd_stat}});

  // interrupt status and line; line follows the status in the same edge
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      irq_stat <= '0;
      o_irq    <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      // a mask written in this cycle counts at once, so the line never lags the register
      o_irq    <= |(next_irq_stat & (wr_mask ? i_wr_data[`DIM_EV_W-1:0] : irq_mask));
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_mux = '0;
    unique case (i_addr)
      `DIM_OFS_CTRL:     rd_mux[`DIM_CTRL_W-1:0] = cfg;
      `DIM_OFS_STATUS:   rd_mux[3:0] = {line_act, o_alarm, o_latched, o_level};
      `DIM_OFS_IRQ_STAT: rd_mux[`DIM_EV_W-1:0] = irq_stat;
      `DIM_OFS_IRQ_MASK: rd_mux[`DIM_EV_W-1:0] = irq_mask;
      default:           rd_mux = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rd_data <= '0;
    else
      o_rd_data <= i_rd_en ? rd_mux : 32'h0;
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  a_sync_depth: assert property (  // RQ12
    $past(i_arst_n, 2) |-> (sync_q == $past(i_line_n, 2)))
    else $error("synchroniser depth wrong");

  a_invert_level: assert property (  // RQ1
    o_level == (~$past(sync_q) ^ $past(cfg.invert)))
    else $error("reported level not inverted as set");

  a_latch_capture: assert property (  // RQ2
    lat_hit |=> o_latched)
    else $error("latch missed transition");

  a_latch_holds: assert property (  // RQ2
    (o_latched && !lat_clr_cmd) |=> o_latched)
    else $error("latch lost without clear");

  a_trig_inactive: assert property (  // RQ3
    (state == DIM_ST_QUIET && cfg.trig == DIM_TRIG_INACT && fall) |=> o_alarm)
    else $error("inactive trigger did not alarm");

  a_trig_active: assert property (  // RQ4
    (state == DIM_ST_QUIET && cfg.trig == DIM_TRIG_ACT && rise) |=> o_alarm)
    else $error("active trigger did not alarm");

  a_trig_disabled: assert property (  // RQ5
    (cfg.trig == DIM_TRIG_OFF) [*2] |-> !o_alarm)
    else $error("alarm while trigger disabled");

  a_auto_clear: assert property (  // RQ6
    (o_alarm && !cfg.manual && !cfg.out_mode && cfg.trig == DIM_TRIG_INACT && rep_level)
      |=> !o_alarm)
    else $error("auto clear failed");

  a_manual_hold: assert property (  // RQ7
    (o_alarm && cfg.manual && !alm_clr_cmd && cfg.trig == $past(cfg.trig)
      && cfg.trig != DIM_TRIG_OFF) |=> o_alarm)
    else $error("manual alarm dropped without clear");

  a_log_event: assert property (  // RQ8
    ($past(cfg.log_en) && $changed(o_alarm)) |-> (o_log_valid && o_log.severity == `DIM_SEV_CRIT))
    else $error("log event missing");

  a_trap_event: assert property (  // RQ9
    ($past(cfg.trap_en) && $changed(o_alarm)) |-> (o_trap_valid && o_trap.raised == o_alarm))
    else $error("trap event missing or wrong flag");

  a_irq_level: assert property (
    o_irq == ((irq_stat & irq_mask) != '0))
    else $error("interrupt line does not follow status");

  // read data never linger past their one cycle
  a_read_once: assert property (
    !$past(i_rd_en) |-> (o_rd_data == '0))
    else $error("read data stood too long");

  a_out_mode_quiet: assert property (  // RQ10
    (cfg.out_mode && !o_alarm) |=> !o_alarm)
    else $error("alarm raised in output mode");

  a_latch_clear: assert property (  // RQ2
    (lat_clr_cmd && !lat_hit) |=> !o_latched)
    else $error("latch not cleared by command");

  c_alarm_raise:  cover property (raise ##[1:50] clear);
  c_manual_clear: cover property (cfg.manual && o_alarm && alm_clr_cmd);
  c_latch_fall:   cover property (cfg.latch == DIM_LATCH_FALL && lat_hit);
  c_irq_read:     cover property (o_irq && rd_stat ##1 !o_irq);
endmodule // dim_monitor
`default_nettype wire

// ===== pkg/dim_defines.svh
`ifndef DIM_DEFINES_SVH
`define DIM_DEFINES_SVH
// How it works
// [RQ1] invert flips reported level, off after reset
// [RQ2] latch none, rising or falling; remembered
// [RQ3] inactive trigger: active-to-inactive raises alarm
// [RQ4] active trigger: inactive-to-active raises alarm
// [RQ5] trigger disabled at reset: never alarms
// [RQ6] auto clear drops alarm when cause leaves
// [RQ7] manual clear holds alarm until host clears
// [RQ8] log event on raise and clear, critical
// [RQ9] trap event on raise and clear, flagged
// [RQ10] channel reads the line by default
// [RQ11] open contact is 0, closed is 1
// [RQ12] two-stage synchroniser before all evaluation

// register byte offsets
`define DIM_OFS_CTRL      8'h00
`define DIM_OFS_STATUS    8'h04
`define DIM_OFS_CMD       8'h08
`define DIM_OFS_IRQ_STAT  8'h0c
`define DIM_OFS_IRQ_MASK  8'h10

// control word width and reset value (all features off, input mode)
`define DIM_CTRL_W        9
`define DIM_CTRL_RST      9'h000

// command bits
`define DIM_CMD_ALM_CLR   0
`define DIM_CMD_LAT_CLR   1

// event bits of status and mask
`define DIM_EV_W          3
`define DIM_EV_RAISE      0
`define DIM_EV_CLEAR      1
`define DIM_EV_LATCH      2

// severity carried by both notifications
`define DIM_SEV_CRIT      3'h2

// synchroniser depth and idle pin level (open contact pulls high)
`define DIM_SYNC_STAGES   2
`define DIM_PIN_IDLE      1'b1
`endif

// ===== pkg/dim_pkg.sv
package dim_pkg;
  // latch setting, code 3 behaves as none
  typedef enum logic [1:0] {
    DIM_LATCH_NONE = 2'h0,
    DIM_LATCH_RISE = 2'h1,
    DIM_LATCH_FALL = 2'h2
  } dim_latch_t;
  // trigger setting, code 3 behaves as disabled
  typedef enum logic [1:0] {
    DIM_TRIG_OFF   = 2'h0,
    DIM_TRIG_INACT = 2'h1,
    DIM_TRIG_ACT   = 2'h2
  } dim_trig_t;
  // alarm state
  typedef enum logic {
    DIM_ST_QUIET = 1'b0,
    DIM_ST_ALARM = 1'b1
  } dim_state_t;
  // control register layout, lsb first: invert, latch, trigger, manual, log, trap, out mode
  typedef struct packed {
    logic       out_mode;
    logic       trap_en;
    logic       log_en;
    logic       manual;
    dim_trig_t  trig;
    dim_latch_t latch;
    logic       invert;
  } dim_cfg_t;
  // log notification
  typedef struct packed {
    logic [2:0] severity;
    logic       value;
  } dim_log_t;
  // trap notification
  typedef struct packed {
    logic [2:0] severity;
    logic       raised;
  } dim_trap_t;
endpackage

// ===== hw/dim_sync.sv
`timescale 1ns/100ps
`default_nettype none
// shift chain synchroniser; only the last stage leaves the module
module dim_sync #(
  parameter int   STAGES  = 2,
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  input  wire logic i_d,
  output logic      o_q
);
  logic [STAGES-1:0] chain;  // stage 0 samples the pin

  // first stage is read only by the next stage
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      chain <= {STAGES{RST_VAL}};
    else
      chain <= {chain[STAGES-2:0], i_d};
  end

  assign o_q = chain[STAGES-1];
endmodule // dim_sync
`default_nettype wire

// ===== tb/dim_contact_model.sv
`timescale 1ns/100ps
`default_nettype none
// dry contact on the pin; the pin is pulled up, so an open contact reads high
module dim_contact_model (
  input  wire logic i_closed,  // contact closed to ground
  output logic      o_line_n   // pin level seen by the monitor
);
  // open: the pull-up wins, never a floating level; closed: tied to ground
  assign o_line_n = i_closed ? 1'b0 : 1'b1;
endmodule // dim_contact_model
`default_nettype wire

// ===== tb/digital_input_alarm_monitor_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "dim_defines.svh"
module digital_input_alarm_monitor_test;
  import dim_pkg::*;
  logic        clk = 1'b0;     // system clock
  logic        rst_n = 1'b0;   // async reset
  logic        closed = 1'b0;  // contact state asked of the model
  logic        line_n;         // pin
  logic [7:0]  addr = 8'h00;   // register bus
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        irq, lvl, lat, alm, log_v, trap_v;
  dim_log_t    log_o;
  dim_trap_t   trap_o;
  dim_cfg_t    cfg;            // model copy of the control word
  logic [4:0]  q_exp[$];       // expected events: {trap, severity, bit}
  logic [4:0]  q_got[$];       // events seen on the pulses
  logic [31:0] d;
  int          failures = 0;
  int          checks_done = 0;
  int          m_lvl, m_lat, m_alm, m_irq, mask;  // behavioural state

  dim_contact_model contact (.i_closed(closed), .o_line_n(line_n));
  dim_monitor dut (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_line_n(line_n), .i_addr(addr),
    .i_wr_data(wdata), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata),
    .o_irq(irq), .o_level(lvl), .o_latched(lat), .o_alarm(alm),
    .o_log_valid(log_v), .o_log(log_o), .o_trap_valid(trap_v), .o_trap(trap_o)
  );

  always #4 clk = ~clk;

  // pulses last one cycle, so capture them at every edge
  always @(posedge clk)
  begin
    if (log_v === 1'b1) q_got.push_back({1'b0, log_o});
    if (trap_v === 1'b1) q_got.push_back({1'b1, trap_o});
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // model side of a raise or clear
  task automatic emit(input int up);
    m_irq |= up ? 1 : 2;
    m_alm = up;
    if (cfg.log_en) q_exp.push_back({1'b0, `DIM_SEV_CRIT, 1'(m_lvl)});
    if (cfg.trap_en) q_exp.push_back({1'b1, `DIM_SEV_CRIT, 1'(up)});
  endtask

  // five edges: two through the synchroniser, one to the outputs, one to catch the pulses, one spare
  task automatic settle();
    int nl, rise, fall;
    repeat (5) @(posedge clk);
    #1;
    nl = closed ^ cfg.invert;
    rise = nl & !m_lvl;
    fall = !nl & m_lvl;
    // output mode freezes edge detection but the level still follows
    if (cfg.out_mode)
    begin
      rise = 0;
      fall = 0;
    end
    m_lvl = nl;
    if ((cfg.latch == DIM_LATCH_RISE && rise) || (cfg.latch == DIM_LATCH_FALL && fall))
    begin
      m_lat = 1;
      m_irq |= 4;
    end
    if (!m_alm && ((cfg.trig == DIM_TRIG_INACT && fall) || (cfg.trig == DIM_TRIG_ACT && rise)))
      emit(1);
    else if (m_alm && !cfg.manual && ((cfg.trig == DIM_TRIG_INACT && rise) || (cfg.trig == DIM_TRIG_ACT && fall)))
      emit(0);
    chk("level", m_lvl, lvl);
    chk("latched", m_lat, lat);
    chk("alarm", m_alm, alm);
    chk("irq", |(m_irq & mask), irq);
    chk("event count", q_exp.size(), q_got.size());
    while (q_exp.size() > 0 && q_got.size() > 0)
      chk("event", q_exp.pop_front(), q_got.pop_front());
    q_exp.delete();
    q_got.delete();
  endtask

  task automatic set_line(input logic c);
    @(posedge clk);
    closed <= c;
    settle();
  endtask

  initial
  begin
    #200000;
    failures++;
    stop_test();
  end

  initial
  begin
    void'($urandom(74660));
    cfg = dim_cfg_t'(`DIM_CTRL_RST);
    {m_lvl, m_lat, m_alm, m_irq, mask} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`DIM_OFS_CTRL, d);
    chk("ctrl reset", 0, d);
    rd_reg(`DIM_OFS_IRQ_MASK, d);
    chk("mask reset", 0, d);
    rd_reg(8'h14, d);
    chk("unmapped", 0, d);
    wr_reg(`DIM_OFS_STATUS, 32'hffffffff);
    rd_reg(`DIM_OFS_STATUS, d);
    chk("status ro", 0, d);
    // sweep every trigger and latch code, spare ones too, with random lines
    for (int i = 0; i < 32; i++)
    begin
      cfg = dim_cfg_t'(9'($urandom));
      cfg.out_mode = (i % 5 == 4);
      cfg.trig = dim_trig_t'(i % 4);
      cfg.latch = dim_latch_t'((i / 4) % 4);
      mask = $urandom % 8;
      wr_reg(`DIM_OFS_IRQ_MASK, mask);
      wr_reg(`DIM_OFS_CTRL, 32'(cfg));
      settle();
      repeat (6) set_line(1'($urandom));
      rd_reg(`DIM_OFS_STATUS, d);
      chk("status", closed * 8 + m_alm * 4 + m_lat * 2 + m_lvl, d);
      rd_reg(`DIM_OFS_IRQ_STAT, d);
      chk("irq status", m_irq, d);
      m_irq = 0;
      // host clear: alarm and latch, before the next setting change
      wr_reg(`DIM_OFS_CMD, 32'h3);
      if (m_alm) emit(0);
      m_lat = 0;
      settle();
    end
    stop_test();
  end
endmodule // digital_input_alarm_monitor_test
`default_nettype wire
